// *** fbie_pkg.sv ***
// Constants, field layout and carrier types of the framer block interrupt enable gate.
// Assumes a single clock domain and an APB register port with 32-bit data.
package fbie_pkg;

    // Number of individual sources that each block can raise.
    localparam int SRC_W = 4;
    // Width of the APB address bus.
    localparam int ADDR_W = 12;

    // Register indexes; the byte address of a register is four times its index.
    localparam logic [7:0] IDX_PENDING = 8'h00;
    localparam logic [7:0] IDX_ENABLE  = 8'h01;
    localparam logic [7:0] IDX_STATUS  = 8'h02;
    localparam logic [7:0] IDX_MASK    = 8'h03;

    // Byte addresses derived from the indexes.
    localparam logic [ADDR_W-1:0] ADDR_PENDING = {2'b00, IDX_PENDING, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_ENABLE  = {2'b00, IDX_ENABLE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = {2'b00, IDX_STATUS, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_MASK    = {2'b00, IDX_MASK, 2'b00};

    // Bit positions shared by the pending, enable, status and mask registers.
    localparam int BIT_NATIONAL = 7;
    localparam int BIT_RESERVED = 6;
    localparam int BIT_CLK_LOSS = 5;
    localparam int BIT_ONE_SEC  = 4;
    localparam int BIT_LINK     = 3;
    localparam int BIT_SLIP     = 2;
    localparam int BIT_ALARM    = 1;
    localparam int BIT_FRAMER   = 0;

    // Reset values.
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET   = 8'hFF;

    // Bits that exist; the reserved bit is held at zero everywhere.
    localparam logic [7:0] LIVE_BITS  = 8'hBF;
    // Bits that are whole blocks, whose sources carry their own enables.
    localparam logic [7:0] BLOCK_BITS = 8'h8F;

    // APB request as driven by the master.
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } fbie_apb_s;

    // Requests from the interrupt sources, one lane per register bit.
    typedef struct packed {
        logic [7:0][SRC_W-1:0] req;          // Raw source requests.
        logic [7:0][SRC_W-1:0] src_en;       // Source-level enables of the block sources.
        logic [7:0]            status_read;  // Pulse: software read that lane's source status.
    } fbie_src_s;

endpackage

// *** fbie_sticky.sv ***
// One sticky flag: set wins over clear.
// Assumes set and clear come from logic on pclk.
`timescale 1ns/1ps
module fbie_sticky (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic set,
    input  wire logic clear,
    output logic      q
);

    logic next_q;  // Next value of the flag.

    // A set in the same cycle as a clear keeps the flag high.
    always_comb begin
        if (set) begin
            next_q = 1'b1;
        end else if (clear) begin
            next_q = 1'b0;
        end else begin
            next_q = q;
        end
    end

    // Registers the flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

endmodule

// *** fbie_top.sv ***
// Block interrupt enable gate of one framer channel with APB registers.
// Assumes source requests and status-read pulses come from logic on pclk.
//
// Function
// - National-bit enable bit 7 gates its block.
// - Link controller enable bit 3 gates its block.
// - Slip buffer enable bit 2 gates its block.
// - Block sources also need their source enables.
// - Bit 5 enables recovered clock loss interrupt.
// - Bit 4 enables one second interrupt.
// - Pending bits clear on source status read.
// - Bits 1 and 0 gate alarm, framer.
`timescale 1ns/1ps
module fbie_top (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire fbie_pkg::fbie_apb_s apb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire fbie_pkg::fbie_src_s src,
    output logic                   irq_out
);

    logic [7:0]  block_interrupt_enable;   // Enable register.
    logic [7:0]  next_enable;              // Next enable register value.
    logic [7:0]  block_interrupt_pending;  // Pending register, per lane.
    logic [7:0]  irq_status;               // Sticky interrupt status.
    logic [7:0]  irq_mask;                 // Interrupt mask.
    logic [7:0]  next_mask;                // Next mask value.
    logic [31:0] next_prdata;              // Read data captured in the setup phase.
    logic [7:0]  pend_set;                 // Lane request after source-level gating.
    logic [7:0]  gated;                    // Pending and enabled lanes.
    logic [7:0]  status_w1c;               // Bits written with one to the status register.
    logic        access;                   // Access phase of a transfer.
    logic        wr_en;                    // Write takes effect this edge.
    logic        mapped;                   // Address hits a register.

    // The slave never stretches a transfer.
    assign pready = 1'b1;
    assign access = apb.psel && apb.penable;
    assign wr_en  = access && apb.pwrite;

    // Address decode.
    always_comb begin
        case (apb.paddr)
            fbie_pkg::ADDR_PENDING: mapped = 1'b1;
            fbie_pkg::ADDR_ENABLE:  mapped = 1'b1;
            fbie_pkg::ADDR_STATUS:  mapped = 1'b1;
            fbie_pkg::ADDR_MASK:    mapped = 1'b1;
            default:                mapped = 1'b0;
        endcase
    end

    // Unmapped addresses answer with an error in the access phase.
    assign pslverr = access && !mapped;

    // Per-lane pending flags, gating and sticky status.
    for (genvar i = 0; i < 8; i++) begin : g_lane
        if (fbie_pkg::BLOCK_BITS[i]) begin : g_block
            // A block source counts only with its source enable set.
            assign pend_set[i] = |(src.req[i] & src.src_en[i]);
        end else if (fbie_pkg::LIVE_BITS[i]) begin : g_single
            // Single sources use the enable register itself as source enable.
            assign pend_set[i] = |src.req[i];
        end else begin : g_reserved
            // The reserved lane never raises anything.
            assign pend_set[i] = 1'b0;
        end

        // Pending flag clears when its source status is read; a new request wins.
        fbie_sticky u_pending (
            .pclk    (pclk),
            .presetn (presetn),
            .set     (pend_set[i]),
            .clear   (src.status_read[i]),
            .q       (block_interrupt_pending[i])
        );

        // Enable bit gates the lane.
        assign gated[i] = block_interrupt_pending[i] && block_interrupt_enable[i];

        // Status bit holds the gated event until written with one.
        fbie_sticky u_status (
            .pclk    (pclk),
            .presetn (presetn),
            .set     (gated[i]),
            .clear   (status_w1c[i]),
            .q       (irq_status[i])
        );
    end

    // Status bits written with one are cleared.
    assign status_w1c = (wr_en && apb.paddr == fbie_pkg::ADDR_STATUS) ? apb.pwdata[7:0] : 8'h00;

    // Interrupt level output from unmasked status.
    assign irq_out = |(irq_status & irq_mask);

    // Next values of the writable registers and of the read data.
    always_comb begin
        next_enable = block_interrupt_enable;
        next_mask   = irq_mask;
        next_prdata = prdata;
        if (wr_en && apb.paddr == fbie_pkg::ADDR_ENABLE) begin
            // The reserved bit ignores writes.
            next_enable = apb.pwdata[7:0] & fbie_pkg::LIVE_BITS;
        end
        if (wr_en && apb.paddr == fbie_pkg::ADDR_MASK) begin
            next_mask = apb.pwdata[7:0] & fbie_pkg::LIVE_BITS;
        end
        if (apb.psel && !apb.penable) begin
            // Read data is prepared in the setup phase.
            case (apb.paddr)
                fbie_pkg::ADDR_PENDING: next_prdata = {24'h00_0000, block_interrupt_pending};
                fbie_pkg::ADDR_ENABLE:  next_prdata = {24'h00_0000, block_interrupt_enable};
                fbie_pkg::ADDR_STATUS:  next_prdata = {24'h00_0000, irq_status};
                fbie_pkg::ADDR_MASK:    next_prdata = {24'h00_0000, irq_mask};
                default:                next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // Registers the writable registers and the read data.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_interrupt_enable <= fbie_pkg::ENABLE_RESET;
            irq_mask               <= fbie_pkg::MASK_RESET & fbie_pkg::LIVE_BITS;
            prdata                 <= 32'h0000_0000;
        end else begin
            block_interrupt_enable <= next_enable;
            irq_mask               <= next_mask;
            prdata                 <= next_prdata;
        end
    end

    // Checks on the gate, all on pclk and disabled in reset.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Write to the enable register in its access phase.
    sequence s_enable_write;
        wr_en && apb.paddr == fbie_pkg::ADDR_ENABLE;
    endsequence

    // Lane pending and enabled while unmasked.
    sequence s_nat_live;
        block_interrupt_pending[7] && block_interrupt_enable[7] && irq_mask[7];
    endsequence

    // The mask must still be open in the cycle in which the status bit appears.
    property p_national_to_pin;
        s_nat_live ##1 irq_mask[7] |-> irq_out;
    endproperty
    a_national_to_pin: assert property (p_national_to_pin) else $error("national lane did not reach pin");

    property p_link_to_status;
        (block_interrupt_pending[3] && block_interrupt_enable[3]) |=> irq_status[3];
    endproperty
    a_link_to_status: assert property (p_link_to_status) else $error("link lane not latched");

    property p_slip_blocked;
        (!block_interrupt_enable[2] && !irq_status[2]) |=> !irq_status[2];
    endproperty
    a_slip_blocked: assert property (p_slip_blocked) else $error("disabled slip lane set status");

    property p_source_gate;
        (src.req[3] != 0 && (src.req[3] & src.src_en[3]) == 0 && !block_interrupt_pending[3])
            |=> !block_interrupt_pending[3];
    endproperty
    a_source_gate: assert property (p_source_gate) else $error("unenabled source set pending");

    property p_clk_loss_pin;
        (src.req[5] != 0 && block_interrupt_enable[5]) ##1 block_interrupt_enable[5] ##1 irq_mask[5] |-> irq_out;
    endproperty
    a_clk_loss_pin: assert property (p_clk_loss_pin) else $error("clock loss did not reach pin");

    property p_one_sec_blocked;
        (!block_interrupt_enable[4] && !irq_status[4]) |=> !irq_status[4];
    endproperty
    a_one_sec_blocked: assert property (p_one_sec_blocked) else $error("disabled one second set status");

    property p_read_clears;
        (src.status_read[0] && !pend_set[0]) |=> !block_interrupt_pending[0];
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("status read did not clear pending");

    property p_alarm_blocked;
        (!block_interrupt_enable[1] && !irq_status[1]) [*2] |=> !irq_status[1];
    endproperty
    a_alarm_blocked: assert property (p_alarm_blocked) else $error("disabled alarm lane set status");

    property p_enable_write;
        s_enable_write |=> block_interrupt_enable == ($past(apb.pwdata[7:0]) & fbie_pkg::LIVE_BITS);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable write wrong or bit 6 set");

endmodule

// *** fbie_top_tb.sv ***
// Self-checking testbench for the framer block interrupt enable gate.
// Assumes fbie_pkg is compiled first and the design answers APB with its own pready.
`timescale 1ns/1ps
module fbie_top_tb;
    logic                pclk;        // Bus clock, 4 ns period.
    logic                presetn;     // Asynchronous reset, active low.
    fbie_pkg::fbie_apb_s apb;         // APB request driven by the bench.
    logic [31:0]         prdata;      // Read data from the design.
    logic                pready;      // Transfer completion from the design.
    logic                pslverr;     // Error response from the design.
    fbie_pkg::fbie_src_s src;         // Source requests, enables and status reads.
    logic                irq_out;     // Level interrupt from the design.
    int                  num_errors;  // Mismatches seen.
    int                  checked;     // Comparisons made.
    logic [31:0]         rd;          // Last read data.
    logic                err;         // Last error response.
    int                  lanes [7];   // Every live lane, block lanes and direct sources alike.

    fbie_top dut_u (.pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata), .pready(pready),
                    .pslverr(pslverr), .src(src), .irq_out(irq_out));

    // The clock toggles every half period.
    initial pclk = 1'b0;
    always #2 pclk = ~pclk;

    // Compares one value and reports a mismatch at once.
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Compares the interrupt pin at the falling edge, once the last rising edge has settled it.
    task automatic check_pin(input string name, input logic exp);
        @(negedge pclk);
        checked++;
        if (irq_out !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", name, exp, irq_out);
        end
    endtask

    // One APB transfer: setup, then access held until pready is sampled high.
    task automatic apb_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                            output logic [31:0] rdata, output logic serr);
        int n;
        @(posedge pclk);
        apb.psel    <= 1'b1;
        apb.penable <= 1'b0;
        apb.pwrite  <= wr;
        apb.paddr   <= addr;
        apb.pwdata  <= wdata;
        @(posedge pclk);
        apb.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            $display("[ERR] pready expected 1 seen %b", pready);
            results();
        end
        rdata = prdata;
        serr = pslverr;
        apb.psel    <= 1'b0;
        apb.penable <= 1'b0;
    endtask

    // Raises one source of a lane, checks gating, masking and both clearing paths.
    task automatic test_lane(input int lane, input logic en);
        logic [31:0] bit_v;
        logic        blk;
        bit_v = 32'h0000_0001 << lane;
        blk = (lane != 5) && (lane != 4);
        apb_xfer(1'b1, fbie_pkg::ADDR_ENABLE, en ? bit_v : 32'h0000_0000, rd, err);
        // A request whose own source enable is off must stay out of block lanes.
        src.req[lane]    <= 4'b0100;
        src.src_en[lane] <= 4'b0010;
        repeat (3) @(posedge pclk);
        apb_xfer(1'b0, fbie_pkg::ADDR_PENDING, 32'h0000_0000, rd, err);
        check("pending without source enable", blk ? 32'h0000_0000 : bit_v, rd);
        src.src_en[lane] <= 4'b0110;
        repeat (3) @(posedge pclk);
        apb_xfer(1'b0, fbie_pkg::ADDR_PENDING, 32'h0000_0000, rd, err);
        check("pending", bit_v, rd);
        apb_xfer(1'b0, fbie_pkg::ADDR_STATUS, 32'h0000_0000, rd, err);
        check("status", en ? bit_v : 32'h0000_0000, rd);
        check_pin("irq", en);
        // Masking the lane must drop the pin while status stays set.
        apb_xfer(1'b1, fbie_pkg::ADDR_MASK, 32'h0000_0000, rd, err);
        check_pin("irq masked", 1'b0);
        apb_xfer(1'b1, fbie_pkg::ADDR_MASK, 32'h0000_00BF, rd, err);
        // Drop the request and pulse the source status read for one cycle.
        src.req[lane]         <= 4'b0000;
        src.status_read[lane] <= 1'b1;
        @(posedge pclk);
        src.status_read[lane] <= 1'b0;
        apb_xfer(1'b0, fbie_pkg::ADDR_PENDING, 32'h0000_0000, rd, err);
        check("pending cleared", 32'h0000_0000, rd);
        apb_xfer(1'b1, fbie_pkg::ADDR_STATUS, bit_v, rd, err);
        apb_xfer(1'b0, fbie_pkg::ADDR_STATUS, 32'h0000_0000, rd, err);
        check("status cleared", 32'h0000_0000, rd);
        check_pin("irq cleared", 1'b0);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence: reset values, register access, then every lane gated and ungated.
    initial begin
        num_errors = 0;
        checked = 0;
        presetn = 1'b0;
        apb = '0;
        src = '0;
        lanes = '{7, 5, 4, 3, 2, 1, 0};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb_xfer(1'b0, fbie_pkg::ADDR_ENABLE, 32'h0000_0000, rd, err);
        check("enable reset", 32'h0000_0000, rd);
        apb_xfer(1'b0, fbie_pkg::ADDR_MASK, 32'h0000_0000, rd, err);
        check("mask reset", 32'h0000_00BF, rd);
        apb_xfer(1'b1, fbie_pkg::ADDR_ENABLE, 32'hFFFF_FFFF, rd, err);
        apb_xfer(1'b0, fbie_pkg::ADDR_ENABLE, 32'h0000_0000, rd, err);
        check("enable reserved bit", 32'h0000_00BF, rd);
        apb_xfer(1'b0, 12'h0F0, 32'h0000_0000, rd, err);
        check("unmapped error", 32'h0000_0001, {31'h0000_0000, err});
        check("unmapped data", 32'h0000_0000, rd);
        // A request on the reserved lane must never show as pending nor reach the pin.
        src.req[6]    <= 4'hF;
        src.src_en[6] <= 4'hF;
        repeat (3) @(posedge pclk);
        apb_xfer(1'b0, fbie_pkg::ADDR_PENDING, 32'h0000_0000, rd, err);
        check("reserved lane pending", 32'h0000_0000, rd);
        src.req[6]    <= 4'h0;
        src.src_en[6] <= 4'h0;
        check_pin("reserved lane irq", 1'b0);
        // Every lane with its enable cleared must never reach the pin.
        foreach (lanes[i]) begin
            test_lane(lanes[i], 1'b0);
        end
        test_lane(7, 1'b1);
        test_lane(3, 1'b1);
        test_lane(2, 1'b1);
        test_lane(5, 1'b1);
        test_lane(4, 1'b1);
        test_lane(1, 1'b1);
        test_lane(0, 1'b1);
        results();
    end

    // Watchdog well beyond the roughly 500 cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        $display("[ERR] watchdog expected done seen running");
        results();
    end
endmodule
